// file: rtl/dual_output_waveform_timer_core.sv
// Purpose: two-output 12-bit waveform timer with axi4-lite registers
// Assumes: one clock; domain crossing modelled as fixed latency
// Notes: outputs are active high, low while stopped
`timescale 1ns/1ps
`default_nettype none
`include "waveform_timer_defs.svh"

module dual_output_waveform_timer_core #(
	parameter int SYNC_LAT = `SYNC_LAT,
	parameter int PROT_WIN = `PROT_WIN,
	parameter int CW       = 12
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             output_a,
	output logic             output_b
);
	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic        aw_have_r;
	logic        w_have_r;
	logic [7:0]  awa_r;
	logic [31:0] wd;
	logic [3:0]  ws;
	logic        wr_go;
	logic [7:0]  wa;
	logic [7:0]  ra;
	logic        wr_map;
	logic        rd_map;
	logic [31:0] rd_mux;

	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wa = {awa_r[7:2], 2'b00};
	assign ra = {s_axi_araddr[7:2], 2'b00};

	// address and data are latched separately, either may come first
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awa_r     <= 8'h00;
			wd        <= 32'h0000_0000;
			ws        <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_r <= 1'b1;
				awa_r     <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_have_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_r <= 1'b1;
				wd       <= s_axi_wdata;
				ws       <= s_axi_wstrb;
			end
			else if (wr_go)
				w_have_r <= 1'b0;
		end
	end

	// responses: one write and one read at a time
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OK;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OK;
		end
		else
		begin
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `RESP_OK : `RESP_ERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_map ? `RESP_OK : `RESP_ERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic                       enable_r;
	logic [6:0]                 main_cfg_r;
	waveform_timer_pkg::mode_t  mode_r;
	logic                       auto_r;
	logic [2:0]                 cmd_r;
	logic [7:0]                 fault_r;
	logic [7:0]                 prot_cnt_r;
	logic [CW-1:0]              buf_aset_r;
	logic [CW-1:0]              buf_aclr_r;
	logic [CW-1:0]              buf_bset_r;
	logic [CW-1:0]              buf_bclr_r;
	logic                       eoc_xfer_r;
	logic                       stop_eoc_r;
	logic [3:0]                 xc_r [3];
	logic [2:0]                 xs;
	logic [2:0]                 xd;
	logic [2:0]                 pend;
	logic                       core_en_r;
	logic                       eoc;
	logic                       core_stop;

	// write decode
	wire sel_main  = wa == `OFS_MAIN;
	wire sel_mode  = wa == `OFS_MODE;
	wire sel_outc  = wa == `OFS_OUTC;
	wire sel_cmd   = wa == `OFS_CMD;
	wire sel_aset  = wa == `OFS_ASET;
	wire sel_aclr  = wa == `OFS_ACLR;
	wire sel_bset  = wa == `OFS_BSET;
	wire sel_bclr  = wa == `OFS_BCLR;
	wire sel_fault = wa == `OFS_FAULT;
	wire sel_prot  = wa == `OFS_PROT;
	assign wr_map = sel_main || sel_mode || sel_outc || sel_cmd || sel_aset || sel_aclr
		|| sel_bset || sel_bclr || sel_fault || sel_prot || wa == `OFS_STAT || wa == `OFS_CNT;

	// ready flags drop while a crossing is outstanding
	wire en_rdy    = !pend[0];
	wire cmd_rdy   = !pend[1];
	wire xfer_busy = pend[2] || eoc_xfer_r;
	wire buf_rdy   = !xfer_busy;
	wire buf_ok    = !core_en_r || buf_rdy;
	wire prot_open = prot_cnt_r != 8'h00;

	wire wen_main  = wr_go && sel_main && ws[0];
	wire wen_en    = wen_main && en_rdy;
	wire wen_cfg   = wen_main && !enable_r;
	wire wen_mode  = wr_go && sel_mode && ws[0] && !enable_r;
	wire wen_outc  = wr_go && sel_outc && ws[0] && !enable_r;
	wire wen_cmd   = wr_go && sel_cmd && ws[0] && core_en_r && cmd_rdy;
	wire wen_fault = wr_go && sel_fault && ws[0] && !enable_r && prot_open;
	wire wen_key   = wr_go && sel_prot && ws[0] && wd[7:0] == `PROT_KEY;
	wire wr_buf    = wr_go && buf_ok;
	wire auto_set  = wr_buf && sel_bclr && ws[1] && auto_r && core_en_r;

	// command delivery in the counter domain
	wire dl_now  = xd[1] && cmd_r[`CMD_NOW_BIT] && !xfer_busy;
	wire dl_eoc  = xd[1] && cmd_r[`CMD_EOC_BIT] && !cmd_r[`CMD_NOW_BIT] && !xfer_busy;
	wire dl_stop = xd[1] && cmd_r[`CMD_STOP_BIT];

	assign xs[0] = wen_en;
	assign xs[1] = wen_cmd && wd[2:0] != 3'h0;
	assign xs[2] = dl_now;

	// fixed-latency crossing counters; done is the last count
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			for (int i = 0; i < 3; i++)
				xc_r[i] <= 4'h0;
		else
			for (int i = 0; i < 3; i++)
				if (xs[i])
					xc_r[i] <= 4'(SYNC_LAT);
				else if (xc_r[i] != 4'h0)
					xc_r[i] <= xc_r[i] - 4'h1;
	end
	for (genvar g = 0; g < 3; g++)
	begin : g_xing
		assign pend[g] = xc_r[g] != 4'h0;
		assign xd[g]   = xc_r[g] == 4'h1;
	end

	// byte-lane merge into a 12-bit field
	function automatic logic [CW-1:0] merge12(input logic [CW-1:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [CW-1:0] v;
		v = old;
		if (s[0])
			v[7:0] = d[7:0];
		if (s[1])
			v[CW-1:8] = d[CW-1:8];
		return v;
	endfunction : merge12

	// enable, static and protected registers
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			enable_r   <= 1'b0;
			main_cfg_r <= `RST_MAIN;
			mode_r     <= waveform_timer_pkg::MODE_ONE;
			auto_r     <= 1'b0;
			fault_r    <= `RST_FAULT;
			prot_cnt_r <= 8'h00;
		end
		else
		begin
			if (eoc && stop_eoc_r)
				enable_r <= 1'b0;
			else if (wen_en)
				enable_r <= wd[`MAIN_EN_BIT];
			if (wen_cfg)
				main_cfg_r <= wd[7:1];
			if (wen_mode)
				mode_r <= waveform_timer_pkg::mode_t'(wd[1:0]);
			if (wen_outc)
				auto_r <= wd[`OUTC_AUTO_BIT];
			if (wen_fault)
				fault_r <= wd[7:0];
			// window closes on use so one key admits one write
			if (wen_key)
				prot_cnt_r <= 8'(PROT_WIN);
			else if (wen_fault)
				prot_cnt_r <= 8'h00;
			else if (prot_open)
				prot_cnt_r <= prot_cnt_r - 8'h01;
		end
	end

	// buffered compares and command strobes
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			buf_aset_r <= `RST_CMP;
			buf_aclr_r <= `RST_CMP;
			buf_bset_r <= `RST_CMP;
			buf_bclr_r <= `RST_CMP;
			cmd_r      <= 3'h0;
		end
		else
		begin
			if (wr_buf && sel_aset)
				buf_aset_r <= merge12(buf_aset_r, wd, ws);
			if (wr_buf && sel_aclr)
				buf_aclr_r <= merge12(buf_aclr_r, wd, ws);
			if (wr_buf && sel_bset)
				buf_bset_r <= merge12(buf_bset_r, wd, ws);
			if (wr_buf && sel_bclr)
				buf_bclr_r <= merge12(buf_bclr_r, wd, ws);
			if (xs[1])
				cmd_r <= wd[2:0];
			else if (xd[1])
				cmd_r <= 3'h0;
		end
	end

	// end-of-cycle requests: a new request beats the clear
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			eoc_xfer_r <= 1'b0;
			stop_eoc_r <= 1'b0;
		end
		else
		begin
			eoc_xfer_r <= dl_eoc || auto_set || (eoc_xfer_r && !eoc && !core_stop);
			stop_eoc_r <= dl_stop || (stop_eoc_r && !eoc && core_en_r);
		end
	end

	// ----------------------------------------
	// counter domain
	// ----------------------------------------
	logic [CW-1:0]              cnt_r;
	logic                       dn_r;
	waveform_timer_pkg::phase_t ph_r;
	waveform_timer_pkg::phase_t ph_nxt;
	logic [CW-1:0]              act_aset_r;
	logic [CW-1:0]              act_aclr_r;
	logic [CW-1:0]              act_bset_r;
	logic [CW-1:0]              act_bclr_r;
	logic [CW-1:0]              cnt_nxt;
	logic                       a_nxt;
	logic                       b_nxt;

	wire is_one  = mode_r == waveform_timer_pkg::MODE_ONE;
	wire is_two  = mode_r == waveform_timer_pkg::MODE_TWO;
	wire is_four = mode_r == waveform_timer_pkg::MODE_FOUR;
	wire is_dual = mode_r == waveform_timer_pkg::MODE_DUAL;
	wire ramp_b  = ph_r == waveform_timer_pkg::PH_DTB || ph_r == waveform_timer_pkg::PH_OTB;
	wire m_as    = cnt_r == act_aset_r;
	wire m_ac    = cnt_r == act_aclr_r;
	wire m_bs    = cnt_r == act_bset_r;
	wire m_bc    = cnt_r == act_bclr_r;
	wire cnt_z   = cnt_r == `RST_CMP;

	// ramp top per mode and phase; a clear never enters dual slope
	wire [CW-1:0] top_v = is_two ? (ramp_b ? act_bclr_r : act_aclr_r) :
		is_four ? (ph_r == waveform_timer_pkg::PH_DTA ? act_aset_r :
		ph_r == waveform_timer_pkg::PH_OTA ? act_aclr_r :
		ph_r == waveform_timer_pkg::PH_DTB ? act_bset_r : act_bclr_r) : act_bclr_r;
	wire at_top = cnt_r == top_v;
	assign eoc = core_en_r && (is_dual ? !dn_r && at_top :
		at_top && (is_one || (is_two && ramp_b) || (is_four && ph_r == waveform_timer_pkg::PH_OTB)));
	wire start     = xd[0] && enable_r && !core_en_r;
	assign core_stop = (xd[0] && !enable_r) || (eoc && stop_eoc_r);
	wire xfer_load = start || xd[2] || (eoc && eoc_xfer_r);

	// next count, direction-free for the ramps
	assign cnt_nxt = is_dual ? (dn_r ? (cnt_z ? cnt_r : cnt_r - 12'h001) :
		(at_top ? cnt_r : cnt_r + 12'h001)) : (at_top ? `RST_CMP : cnt_r + 12'h001);
	wire dn_nxt = dn_r ? !cnt_z : at_top;

	// phase walk through dead and on times
	always_comb
	begin
		ph_nxt = ph_r;
		if (at_top && is_four)
			case (ph_r)
				waveform_timer_pkg::PH_DTA: ph_nxt = waveform_timer_pkg::PH_OTA;
				waveform_timer_pkg::PH_OTA: ph_nxt = waveform_timer_pkg::PH_DTB;
				waveform_timer_pkg::PH_DTB: ph_nxt = waveform_timer_pkg::PH_OTB;
				default:                    ph_nxt = waveform_timer_pkg::PH_DTA;
			endcase
		else if (at_top && is_two)
			ph_nxt = ramp_b ? waveform_timer_pkg::PH_DTA : waveform_timer_pkg::PH_DTB;
	end

	// output levels; a clear wins over a set on equal values
	always_comb
	begin
		a_nxt = output_a;
		b_nxt = output_b;
		case (mode_r)
			waveform_timer_pkg::MODE_ONE:
			begin
				a_nxt = m_bc ? 1'b0 : m_ac ? 1'b0 : m_as ? 1'b1 : output_a;
				b_nxt = m_bc ? 1'b0 : m_bs ? 1'b1 : output_b;
			end
			waveform_timer_pkg::MODE_TWO:
			begin
				a_nxt = !ramp_b && !at_top && (m_as || output_a);
				b_nxt = ramp_b && !at_top && (m_bs || output_b);
			end
			waveform_timer_pkg::MODE_FOUR:
			begin
				a_nxt = ph_nxt == waveform_timer_pkg::PH_OTA;
				b_nxt = ph_nxt == waveform_timer_pkg::PH_OTB;
			end
			default:
			begin
				a_nxt = m_as ? dn_r : output_a;
				b_nxt = m_bs ? !dn_r : output_b;
			end
		endcase
	end

	// counter, direction, phase and outputs
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			core_en_r <= 1'b0;
			cnt_r     <= `RST_CMP;
			dn_r      <= 1'b0;
			ph_r      <= waveform_timer_pkg::PH_DTA;
			output_a  <= 1'b0;
			output_b  <= 1'b0;
		end
		else if (start)
		begin
			core_en_r <= 1'b1;
			cnt_r     <= is_dual ? buf_bclr_r : `RST_CMP;
			dn_r      <= is_dual;
			ph_r      <= waveform_timer_pkg::PH_DTA;
			output_a  <= 1'b0;
			output_b  <= 1'b0;
		end
		else if (core_stop)
		begin
			core_en_r <= 1'b0;
			cnt_r     <= `RST_CMP;
			dn_r      <= 1'b0;
			ph_r      <= waveform_timer_pkg::PH_DTA;
			output_a  <= 1'b0;
			output_b  <= 1'b0;
		end
		else if (core_en_r)
		begin
			cnt_r    <= cnt_nxt;
			dn_r     <= is_dual && dn_nxt;
			ph_r     <= ph_nxt;
			output_a <= a_nxt;
			output_b <= b_nxt;
		end
	end

	// active compares change only at a transfer, never mid-write
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			act_aset_r <= `RST_CMP;
			act_aclr_r <= `RST_CMP;
			act_bset_r <= `RST_CMP;
			act_bclr_r <= `RST_CMP;
		end
		else if (xfer_load)
		begin
			act_aset_r <= buf_aset_r;
			act_aclr_r <= buf_aclr_r;
			act_bset_r <= buf_bset_r;
			act_bclr_r <= buf_bclr_r;
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb
	begin
		rd_map = 1'b1;
		if (ra == `OFS_MAIN)
			rd_mux = {24'h0, main_cfg_r, enable_r};
		else if (ra == `OFS_MODE)
			rd_mux = {30'h0, mode_r};
		else if (ra == `OFS_OUTC)
			rd_mux = {31'h0, auto_r};
		else if (ra == `OFS_CMD)
			rd_mux = {29'h0, cmd_r};
		else if (ra == `OFS_STAT)
			rd_mux = {28'h0, core_en_r, buf_rdy, cmd_rdy, en_rdy};
		else if (ra == `OFS_ASET)
			rd_mux = {20'h0, buf_aset_r};
		else if (ra == `OFS_ACLR)
			rd_mux = {20'h0, buf_aclr_r};
		else if (ra == `OFS_BSET)
			rd_mux = {20'h0, buf_bset_r};
		else if (ra == `OFS_BCLR)
			rd_mux = {20'h0, buf_bclr_r};
		else if (ra == `OFS_FAULT)
			rd_mux = {24'h0, fault_r};
		else if (ra == `OFS_CNT)
			rd_mux = {20'h0, cnt_r};
		else
		begin
			rd_mux = 32'h0000_0000;
			rd_map = ra == `OFS_PROT;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	en_ignored_a: assert property ((wen_main && !en_rdy && !enable_r) |=> !enable_r)
		else $error("enable changed while crossing pending");
	cmd_gate_a: assert property ((wr_go && sel_cmd && !core_en_r && !xd[1]) |=> $stable(cmd_r))
		else $error("command taken while disabled");
	cmd_clear_a: assert property (xd[1] |=> cmd_r == 3'h0)
		else $error("command strobe not cleared");
	now_xfer_a: assert property ((dl_now && core_en_r) |-> ##[1:8] xd[2])
		else $error("transfer now never completed");
	busy_ignore_a: assert property ((xd[1] && xfer_busy) |=> !pend[2] || $past(pend[2]))
		else $error("transfer started while busy");
	static_lock_a: assert property ((wr_go && sel_mode && enable_r) |=> $stable(mode_r))
		else $error("static register written while enabled");
	fault_prot_a: assert property ((wr_go && sel_fault && !prot_open) |=> $stable(fault_r))
		else $error("fault config changed without key");
	one_wrap_a: assert property ((core_en_r && is_one && m_bc && !core_stop) |=> cnt_z)
		else $error("one ramp did not wrap at top");
	bclr_clear_a: assert property ((core_en_r && is_one && m_bc) |=> !output_a && !output_b)
		else $error("b clear match left an output high");
	ds_turn_a: assert property ((core_en_r && is_dual && dn_r && cnt_z && !core_stop) |=> !dn_r && cnt_z)
		else $error("dual slope did not turn at zero");
	ds_seta_a: assert property ((core_en_r && is_dual && dn_r && m_as && !core_stop) |=> output_a)
		else $error("output a not set counting down");
	ds_start_a: assert property ((start && is_dual) |=> dn_r && cnt_r == $past(buf_bclr_r) && !output_b)
		else $error("dual slope start wrong");
	stop_eoc_a: assert property ((eoc && stop_eoc_r) |=> !core_en_r && !enable_r)
		else $error("stop at cycle end missed");
	dis_stop_a: assert property ((xd[0] && !enable_r) |=> !core_en_r && !output_a && !output_b)
		else $error("disable did not stop timer");

	one_eoc_c: cover property (eoc && is_one);
	four_eoc_c: cover property (eoc && is_four);
	ds_eoc_c: cover property (eoc && is_dual && output_b);
	auto_c: cover property (auto_set ##[1:40] (eoc && eoc_xfer_r));
endmodule : dual_output_waveform_timer_core
`default_nettype wire

// file: rtl/waveform_timer_defs.svh
// Purpose: offsets, field positions, reset values and counts
// Assumes: included by bare name
// Notes: definitions only
`ifndef WAVEFORM_TIMER_DEFS_SVH
`define WAVEFORM_TIMER_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_MAIN  8'h00
`define OFS_MODE  8'h04
`define OFS_OUTC  8'h08
`define OFS_CMD   8'h0c
`define OFS_STAT  8'h10
`define OFS_ASET  8'h14
`define OFS_ACLR  8'h18
`define OFS_BSET  8'h1c
`define OFS_BCLR  8'h20
`define OFS_FAULT 8'h24
`define OFS_PROT  8'h28
`define OFS_CNT   8'h2c
// ----------------------------------------
// field positions
// ----------------------------------------
`define MAIN_EN_BIT   0
`define OUTC_AUTO_BIT 0
`define CMD_NOW_BIT   1'b0
`define CMD_EOC_BIT   1
`define CMD_STOP_BIT  2
// ----------------------------------------
// reset values, key, counts
// ----------------------------------------
`define RST_CMP   12'h000
`define RST_MAIN  7'h00
`define RST_FAULT 8'h00
`define PROT_KEY  8'h5a
`define PROT_WIN  4
`define SYNC_LAT  2
`define RESP_OK   2'h0
`define RESP_ERR  2'h2
`endif

// file: rtl/waveform_timer_pkg.sv
// Purpose: types of the waveform timer
// Assumes: nothing
// Notes: constants live in the defs header
package waveform_timer_pkg;
	typedef enum logic [1:0] {
		MODE_ONE  = 2'h0,
		MODE_TWO  = 2'h1,
		MODE_FOUR = 2'h2,
		MODE_DUAL = 2'h3
	} mode_t;
	typedef enum logic [3:0] {
		PH_DTA = 4'h1,
		PH_OTA = 4'h2,
		PH_DTB = 4'h4,
		PH_OTB = 4'h8
	} phase_t;
endpackage : waveform_timer_pkg

// file: verif/pin_load_model.sv
// Purpose: load on one output pin that times its rising edges
// Assumes: the pin is a registered level
// Notes: period is core_clk cycles between two rises
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        pin,
	output logic      [15:0] period,
	output logic      [7:0]  rises
);
	logic        pin_r;
	logic [15:0] cnt_r;
	// ----------------------------------------
	// edge timer
	// ----------------------------------------
	// a load only listens, so nothing is driven back
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_r  <= 1'b0;
			cnt_r  <= 16'h0001;
			period <= 16'h0000;
			rises  <= 8'h00;
		end
		else
		begin
			pin_r <= pin;
			cnt_r <= (pin && !pin_r) ? 16'h0001 : cnt_r + 16'h0001;
			if (pin && !pin_r)
			begin
				period <= cnt_r;
				rises  <= rises + 8'h01;
			end
		end
	end
endmodule : pin_load_model
`default_nettype wire

// file: verif/dual_output_waveform_timer_core_tb.sv
// Purpose: self-checking bench for the waveform timer core
// Assumes: register map and crossing latency of the core
// Notes: periods are measured at the pins by the load models
`timescale 1ns/1ps
`default_nettype none
`include "waveform_timer_defs.svh"
module dual_output_waveform_timer_core_tb;
	logic        core_clk;
	logic        nrst;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, out_a, out_b;
	logic [15:0] per_a, per_b;
	logic [7:0]  rise_a, rise_b;
	logic [31:0] rd_d;
	logic [1:0]  rd_r;
	logic [1:0]  wr_rsp;
	logic [15:0] exp_per [4];
	int          num_errors = 0;
	int          checked = 0;
	int          cycles = 0;
	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// the whole run needs under a thousand cycles, so this only cuts a hang
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors = num_errors + 1;
			end_sim();
		end
	end
	dual_output_waveform_timer_core dual_output_waveform_timer_core_i (
		.core_clk(core_clk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.output_a(out_a), .output_b(out_b)
	);
	pin_load_model pin_load_model_i (.core_clk(core_clk), .nrst(nrst), .pin(out_a), .period(per_a), .rises(rise_a));
	pin_load_model pin_load_model_b_i (.core_clk(core_clk), .nrst(nrst), .pin(out_b), .period(per_b), .rises(rise_b));
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			num_errors = num_errors + 1;
		end
	endtask : chk
	// address and data are offered together and each drops once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_d;
		logic w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_d && w_d))
		begin
			@(posedge core_clk);
			if (awvalid && awready) aw_d = 1'b1;
			if (wvalid && wready) w_d = 1'b1;
			awvalid <= !aw_d;
			wvalid <= !w_d;
		end
		do @(posedge core_clk); while (bvalid !== 1'b1);
		wr_rsp = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		rd_d = rdata;
		rd_r = rresp;
	endtask : rd
	// software polls status before touching crossed state
	task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
		do rd(`OFS_STAT); while ((rd_d & m) !== v);
	endtask : wait_stat
	// four rises leave two whole cycles of the new setting on each pin
	task automatic per(input logic [15:0] e);
		logic [7:0] r0;
		r0 = rise_b;
		while (rise_b !== r0 + 8'h04) @(posedge core_clk);
		chk({16'h0000, per_b}, {16'h0000, e});
		chk({16'h0000, per_a}, {16'h0000, e});
	endtask : per
	task automatic end_sim();
		$display("checks=%0d errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		nrst = 1'b0;
		{awaddr, araddr, wdata} = 48'h0000_0000_0000;
		{awvalid, wvalid, arvalid} = 3'h0;
		{bready, rready, wstrb} = 6'h3f;
		exp_per = '{16'h000a, 16'h0010, 16'h001b, 16'h0014};
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		rd(`OFS_STAT);
		chk(rd_d, 32'h0000_0007);
		rd(`OFS_BCLR);
		chk(rd_d, 32'h0000_0000);
		rd(8'h30);
		chk({30'h0, rd_r}, {30'h0, `RESP_ERR});
		wr(`OFS_ASET, 32'h0000_0002);
		wr(`OFS_ACLR, 32'h0000_0005);
		wr(`OFS_BSET, 32'h0000_0007);
		wr(`OFS_BCLR, 32'h0000_0009);
		// every mode from dual down to one ramp, which stays running
		for (int m = 3; m >= 0; m--)
		begin
			wr(`OFS_MODE, 32'(m));
			wait_stat(32'h1, 32'h1);
			wr(`OFS_MAIN, 32'h0000_0001);
			per(exp_per[m]);
			wr(`OFS_MODE, 32'(3 - m));
			rd(`OFS_MODE);
			chk(rd_d, 32'(m));
			if (m != 0)
			begin
				wait_stat(32'h1, 32'h1);
				wr(`OFS_MAIN, 32'h0000_0000);
				wait_stat(32'h8, 32'h0);
				chk({30'h0, out_a, out_b}, 32'h0);
			end
		end
		wait_stat(32'h4, 32'h4);
		wr(`OFS_BCLR, 32'h0000_000d);
		wait_stat(32'h2, 32'h2);
		wr(`OFS_CMD, 32'h0000_0001);
		per(16'h000e);
		rd(`OFS_CMD);
		chk(rd_d, 32'h0000_0000);
		wait_stat(32'h2, 32'h2);
		wr(`OFS_CMD, 32'h0000_0004);
		wait_stat(32'h8, 32'h0);
		chk({31'h0, out_b}, 32'h0);
		rd(`OFS_STAT);
		chk(rd_d, 32'h0000_0007);
		// stopped: commands refused, fault config needs the key first
		wr(`OFS_CMD, 32'h0000_0001);
		rd(`OFS_CMD);
		chk(rd_d, 32'h0000_0000);
		wr(`OFS_FAULT, 32'h0000_003c);
		rd(`OFS_FAULT);
		chk(rd_d, 32'h0000_0000);
		wr(`OFS_PROT, {24'h0, `PROT_KEY});
		wr(`OFS_FAULT, 32'h0000_003c);
		rd(`OFS_FAULT);
		chk(rd_d, 32'h0000_003c);
		wr(8'h30, 32'h0000_0000);
		chk({30'h0, wr_rsp}, {30'h0, `RESP_ERR});
		wr(`OFS_OUTC, 32'h0000_0001);
		wr(`OFS_MAIN, 32'h0000_000b);
		chk({30'h0, wr_rsp}, {30'h0, `RESP_OK});
		wait_stat(32'h5, 32'h5);
		// a high-lane write with auto transfer lands at the cycle end
		wr(`OFS_BCLR, 32'h0000_0011);
		per(16'h0012);
		wait_stat(32'h1, 32'h1);
		wr(`OFS_MAIN, 32'h0000_0007);
		rd(`OFS_MAIN);
		chk(rd_d, 32'h0000_000b);
		// low lane only, so no auto transfer; the cycle-end command moves it
		wait_stat(32'h4, 32'h4);
		wstrb <= 4'h1;
		wr(`OFS_BCLR, 32'h0000_000f);
		wstrb <= 4'hf;
		wait_stat(32'h2, 32'h2);
		wr(`OFS_CMD, 32'h0000_0002);
		wait_stat(32'h2, 32'h2);
		wr(`OFS_CMD, 32'h0000_0001);
		per(16'h0010);
		end_sim();
	end
endmodule : dual_output_waveform_timer_core_tb
`default_nettype wire
